// ===== hdl/eca_defines.svh
// eca_defines.svh - offsets, bit positions, reset values and counts
`ifndef ECA_DEFINES_SVH
`define ECA_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ECA_IDX_CRC_EXPOSE 10'h02e
`define ECA_IDX_ACS_EXPOSE 10'h06a
`define ECA_IDX_CRC_CTRL 10'h168
`define ECA_IDX_ACS_CAP 10'h190
`define ECA_IDX_ACS_CTRL 10'h196

// ----------------------------------------------------------------
// address spaces: haddr[15:12], 0 is misc, 1..4 are the bridges
// ----------------------------------------------------------------
`define ECA_SPACE_MISC 4'h0
`define ECA_NUM_PORTS 4

// ----------------------------------------------------------------
// exposure bit positions in the misc registers
// ----------------------------------------------------------------
`define ECA_CHK_ONE 25
`define ECA_CHK_TWO 26
`define ECA_CHK_THREE_A 27
`define ECA_CHK_THREE_B 29
`define ECA_GEN_ONE 20
`define ECA_GEN_TWO 21
`define ECA_GEN_THREE_A 22
`define ECA_GEN_THREE_B 24
`define ECA_ACS_EXPOSE_BIT 2

// ----------------------------------------------------------------
// bridge ecrc control field positions
// ----------------------------------------------------------------
`define ECA_GEN_CAP_BIT 5
`define ECA_GEN_EN_BIT 6
`define ECA_CHK_CAP_BIT 7
`define ECA_CHK_EN_BIT 8

// ----------------------------------------------------------------
// reset values and fixed read values
// ----------------------------------------------------------------
`define ECA_RST_CRC_EXPOSE 32'h0000_0000
`define ECA_RST_ACS_EXPOSE 32'h0000_0004
`define ECA_RST_ACS_CTRL 7'h00
`define ECA_ACS_CAP_HDR 32'h0001_000d
`define ECA_ACS_CTRL_W 7

`endif

// ===== hdl/eca_pkg.sv
// eca_pkg.sv - types shared by the exposure block
package eca_pkg;

  // ----------------------------------------------------------------
  // bus answer state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ECA_ST_IDLE = 1'b0, // zero wait, ready high
    ECA_ST_RDWAIT = 1'b1 // read data being fetched
  } eca_bus_st_t;

  // port cores in bridge order
  typedef enum logic [1:0] {
    ECA_CORE_ONE = 2'b00,
    ECA_CORE_TWO = 2'b01,
    ECA_CORE_THREE_A = 2'b10,
    ECA_CORE_THREE_B = 2'b11
  } eca_core_t;

endpackage : eca_pkg

// ===== hdl/eca_port_if.sv
// eca_port_if.sv - link between register front end and one bridge
`timescale 1ns/1ps
`default_nettype none

interface eca_port_if;
  logic gen_exposed; // core allows generation
  logic chk_exposed; // core allows checking
  logic acs_exposed; // acs capability visible
  logic wr_en; // one-cycle write to this bridge
  logic [9:0] wr_idx; // register index
  logic [31:0] wr_data; // write data
  logic [31:0] crc_rd; // ecrc control read value
  logic [31:0] acs_rd; // acs control read value
  logic append_en; // append crc downstream
  logic check_en; // check crc on receive

  modport ctl (output gen_exposed, chk_exposed, acs_exposed, wr_en,
    wr_idx, wr_data, input crc_rd, acs_rd, append_en, check_en);
  modport bridge (input gen_exposed, chk_exposed, acs_exposed, wr_en,
    wr_idx, wr_data, output crc_rd, acs_rd, append_en, check_en);
endinterface : eca_port_if

`default_nettype wire

// ===== hdl/eca_bridge.sv
// eca_bridge.sv - ecrc and acs control registers of one root port
`timescale 1ns/1ps
`default_nettype none
`include "eca_defines.svh"

module eca_bridge
  import eca_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  eca_port_if.bridge p
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic gen_en; // generation enable
  logic chk_en; // check enable
  logic [`ECA_ACS_CTRL_W-1:0] acs_ctrl; // acs control bits
  logic next_gen_en;
  logic next_chk_en;
  logic crc_wr; // write hits ecrc control
  logic acs_wr; // write hits acs control

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign crc_wr = p.wr_en && (p.wr_idx == `ECA_IDX_CRC_CTRL);
  assign acs_wr = p.wr_en && (p.wr_idx == `ECA_IDX_ACS_CTRL);
  // enables only stick while the core exposes the capability
  assign next_gen_en = (crc_wr ? p.wr_data[`ECA_GEN_EN_BIT] : gen_en)
    & p.gen_exposed; // see (RQ6)
  assign next_chk_en = (crc_wr ? p.wr_data[`ECA_CHK_EN_BIT] : chk_en)
    & p.chk_exposed; // see (RQ7)

  // enables and acs control, cleared at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gen_en <= 1'b0; // see (RQ19)
      chk_en <= 1'b0; // see (RQ19)
      acs_ctrl <= `ECA_RST_ACS_CTRL;
    end else begin
      gen_en <= next_gen_en;
      chk_en <= next_chk_en;
      if (acs_wr) begin
        acs_ctrl <= p.wr_data[`ECA_ACS_CTRL_W-1:0]; // see (RQ18)
      end
    end
  end

  // ----------------------------------------------------------------
  // read values and controls for the datapath
  // ----------------------------------------------------------------
  // standard aer ecrc fields, capability bits mirror the core
  assign p.crc_rd = {23'h000000, chk_en, p.chk_exposed, gen_en,
    p.gen_exposed, 5'h00}; // see (RQ5)
  assign p.acs_rd = p.acs_exposed ? {25'h0000000, acs_ctrl} : 32'h0;
  assign p.append_en = gen_en; // see (RQ6)
  assign p.check_en = chk_en; // see (RQ7)

endmodule : eca_bridge

`default_nettype wire

// ===== hdl/eca_top.sv
// eca_top.sv - ecrc and acs capability exposure with ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "eca_defines.svh"

// Notes on behaviour
// (RQ1) per-core bits in 0x2e expose ecrc checking
// (RQ2) per-core bits in 0x2e expose ecrc generation
// (RQ3) all bridges of a core share exposure
// (RQ4) software exposes aer before any ecrc setup
// (RQ5) bridges hold ecrc control at 0x168
// (RQ6) generation enable bit 6 appends crc downstream
// (RQ7) check enable bit 8 checks received crc
// (RQ8) crc may reach endpoints that ignore it
// (RQ9) software exposes per endpoint crc abilities
// (RQ10) wide switch links need full generation, no hotplug
// (RQ11) endpoint directly below: leave crc off
// (RQ12) endpoint check capable: pair with port generation
// (RQ13) endpoint generation capable: pair with port check
// (RQ14) acs capability visible straight after reset
// (RQ15) bit 2 of 0x6a exposes acs
// (RQ16) bridges hold acs capability at 0x190
// (RQ17) firmware enables recommended acs features
// (RQ18) root port acs control sits at 0x196
// (RQ19) ecrc exposure and enable bits reset to zero
module eca_top
  import eca_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic hresp,
  output var logic [31:0] hrdata,
  output logic [3:0] crc_append_en,
  output logic [3:0] crc_check_en,
  output logic [3:0] crc_gen_visible,
  output logic [3:0] crc_chk_visible,
  output logic acs_visible
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // space to bridge: bit 2 is a hit flag, bits 1:0 the bridge number
  function automatic logic [2:0] eca_port_of(input logic [3:0] space);
    logic [3:0] idx;
    idx = space - 4'h1;
    eca_port_of = {(space != `ECA_SPACE_MISC) &&
      (space <= 4'(`ECA_NUM_PORTS)), idx[1:0]};
  endfunction : eca_port_of

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  eca_bus_st_t bus_st; // read wait tracker
  logic wr_pend; // write data phase in progress
  logic [3:0] wr_space; // latched write space
  logic [9:0] wr_idx; // latched write index
  logic [3:0] rd_space; // latched read space
  logic [9:0] rd_idx; // latched read index
  logic [31:0] crc_expose; // ecrc exposure register
  logic [31:0] acs_expose; // acs exposure register

  // ----------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------
  wire addr_ok = hsel && hready && htrans[1]; // nonseq or seq taken
  wire wr_accept = addr_ok && hwrite && (hsize == 3'b010);
  wire rd_accept = addr_ok && !hwrite;
  wire [2:0] wr_port = eca_port_of(wr_space); // data phase target
  wire [2:0] rd_port = eca_port_of(rd_space); // read target
  wire wr_misc = wr_pend && (wr_space == `ECA_SPACE_MISC);
  wire wr_crc_exp = wr_misc && (wr_idx == `ECA_IDX_CRC_EXPOSE);
  wire wr_acs_exp = wr_misc && (wr_idx == `ECA_IDX_ACS_EXPOSE);

  // ----------------------------------------------------------------
  // bridges, one per root port, one root port per core
  // ----------------------------------------------------------------
  eca_port_if port_if[`ECA_NUM_PORTS] ();
  logic [31:0] crc_rd_a [`ECA_NUM_PORTS]; // ecrc control read
  logic [31:0] acs_rd_a [`ECA_NUM_PORTS]; // acs control read

  genvar gi;
  generate
    for (gi = 0; gi < `ECA_NUM_PORTS; gi++) begin : g_port
      // every bridge of a core sees the same core bit
      assign port_if[gi].gen_exposed = crc_gen_visible[gi]; // see (RQ3)
      assign port_if[gi].chk_exposed = crc_chk_visible[gi]; // see (RQ3)
      assign port_if[gi].acs_exposed = acs_visible;
      assign port_if[gi].wr_en = wr_pend && wr_port[2] &&
        (wr_port[1:0] == 2'(gi));
      assign port_if[gi].wr_idx = wr_idx;
      assign port_if[gi].wr_data = hwdata;
      assign crc_rd_a[gi] = port_if[gi].crc_rd;
      assign acs_rd_a[gi] = port_if[gi].acs_rd;
      // crc is appended whatever the endpoint supports
      assign crc_append_en[gi] = port_if[gi].append_en; // see (RQ8)
      assign crc_check_en[gi] = port_if[gi].check_en;

      eca_bridge u_bridge (
        .hclk(hclk),
        .hresetn(hresetn),
        .p(port_if[gi].bridge)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // exposure outputs, straight from the registers
  // ----------------------------------------------------------------
  assign crc_chk_visible = {crc_expose[`ECA_CHK_THREE_B],
    crc_expose[`ECA_CHK_THREE_A], crc_expose[`ECA_CHK_TWO],
    crc_expose[`ECA_CHK_ONE]}; // see (RQ1)
  assign crc_gen_visible = {crc_expose[`ECA_GEN_THREE_B],
    crc_expose[`ECA_GEN_THREE_A], crc_expose[`ECA_GEN_TWO],
    crc_expose[`ECA_GEN_ONE]}; // see (RQ2)
  assign acs_visible = acs_expose[`ECA_ACS_EXPOSE_BIT]; // see (RQ15)

  // ----------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------
  wire rd_misc = (rd_space == `ECA_SPACE_MISC);
  wire [31:0] misc_val = (rd_idx == `ECA_IDX_CRC_EXPOSE) ? crc_expose :
    (rd_idx == `ECA_IDX_ACS_EXPOSE) ? acs_expose : 32'h0;
  wire [31:0] acs_hdr = acs_visible ? `ECA_ACS_CAP_HDR : 32'h0;
  wire [31:0] port_val =
    (rd_idx == `ECA_IDX_CRC_CTRL) ? crc_rd_a[rd_port[1:0]] : // see (RQ5)
    (rd_idx == `ECA_IDX_ACS_CAP) ? acs_hdr : // see (RQ16)
    (rd_idx == `ECA_IDX_ACS_CTRL) ? acs_rd_a[rd_port[1:0]] : 32'h0;
  // unmapped reads answer zero
  wire [31:0] rd_val = rd_misc ? misc_val :
    (rd_port[2] ? port_val : 32'h0);

  // ----------------------------------------------------------------
  // exposure registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_expose <= `ECA_RST_CRC_EXPOSE; // see (RQ19)
      acs_expose <= `ECA_RST_ACS_EXPOSE; // see (RQ14)
    end else begin
      if (wr_crc_exp) begin
        crc_expose <= hwdata; // see (RQ1) (RQ2)
      end
      if (wr_acs_exp) begin
        acs_expose <= hwdata; // see (RQ15)
      end
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite data phase tracking
  // ----------------------------------------------------------------
  // writes take no wait; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_space <= 4'h0;
      wr_idx <= 10'h000;
      rd_space <= 4'h0;
      rd_idx <= 10'h000;
    end else begin
      wr_pend <= wr_accept;
      if (wr_accept) begin
        wr_space <= haddr[15:12];
        wr_idx <= haddr[11:2];
      end
      if (rd_accept) begin
        rd_space <= haddr[15:12];
        rd_idx <= haddr[11:2];
      end
    end
  end

  // answer side: ready, response and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st <= ECA_ST_IDLE;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      hresp <= 1'b0;
      case (bus_st)
        ECA_ST_IDLE: begin
          if (rd_accept) begin
            bus_st <= ECA_ST_RDWAIT;
            hreadyout <= 1'b0;
          end
        end
        ECA_ST_RDWAIT: begin
          bus_st <= ECA_ST_IDLE;
          hrdata <= rd_val;
          hreadyout <= 1'b1;
        end
        default: begin
          bus_st <= ECA_ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic seen_crc_wr; // helper: ecrc exposure written since reset
  logic seen_acs_wr; // helper: acs exposure written since reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_crc_wr <= 1'b0;
      seen_acs_wr <= 1'b0;
    end else begin
      seen_crc_wr <= seen_crc_wr | wr_crc_exp;
      seen_acs_wr <= seen_acs_wr | wr_acs_exp;
    end
  end

  wire wr_port_crc = wr_pend && wr_port[2] &&
    (wr_idx == `ECA_IDX_CRC_CTRL);
  wire rd_port_hit = rd_accept && eca_port_of(haddr[15:12]) >= 3'h4;

  // exposure writes show on the outputs the cycle after
  a_chk_expose_map: assert property (wr_crc_exp |=> // see (RQ1)
    crc_chk_visible == {$past(hwdata[29]), $past(hwdata[27:25])})
    else $error("check exposure does not follow write");
  a_gen_expose_map: assert property (wr_crc_exp |=> // see (RQ2)
    crc_gen_visible == {$past(hwdata[24]), $past(hwdata[22:20])})
    else $error("generation exposure does not follow write");
  // an enable only stands while its core was exposed the cycle before
  a_core_gates_enable: assert property ( // see (RQ3)
    ((crc_append_en & ~$past(crc_gen_visible)) == 4'h0) &&
    ((crc_check_en & ~$past(crc_chk_visible)) == 4'h0))
    else $error("enable set on a core without exposure");
  // enable writes land while the core is exposed
  a_gen_enable_write: assert property ( // see (RQ6)
    wr_port_crc && crc_gen_visible[wr_port[1:0]] |=>
    crc_append_en[$past(wr_port[1:0])] == $past(hwdata[6]))
    else $error("append enable does not follow write");
  a_chk_enable_write: assert property ( // see (RQ7)
    wr_port_crc && crc_chk_visible[wr_port[1:0]] |=>
    crc_check_en[$past(wr_port[1:0])] == $past(hwdata[8]))
    else $error("check enable does not follow write");
  // reads answer two edges after the address edge
  a_crc_ctrl_read: assert property ( // see (RQ5)
    rd_port_hit && haddr[11:2] == `ECA_IDX_CRC_CTRL |-> ##2
    hrdata[5] == $past(crc_gen_visible[rd_port[1:0]], 1) &&
    hrdata[31:9] == 23'h000000)
    else $error("ecrc control read wrong");
  a_acs_hdr_read: assert property ( // see (RQ16)
    rd_port_hit && haddr[11:2] == `ECA_IDX_ACS_CAP |-> ##2
    hrdata == ($past(acs_visible) ? `ECA_ACS_CAP_HDR : 32'h0))
    else $error("acs capability header read wrong");
  // acs control and misc register reads
  a_acs_ctrl_read: assert property ( // see (RQ18)
    rd_port_hit && haddr[11:2] == `ECA_IDX_ACS_CTRL |-> ##2
    hrdata[31:7] == 25'h0 && ($past(acs_visible) || hrdata == 32'h0))
    else $error("acs control read wrong");
  a_misc_crc_read: assert property ( // see (RQ1) (RQ2)
    rd_accept && haddr[15:12] == `ECA_SPACE_MISC &&
    haddr[11:2] == `ECA_IDX_CRC_EXPOSE |-> ##2 hrdata == $past(crc_expose))
    else $error("ecrc exposure read wrong");
  a_unmapped_read: assert property (rd_accept &&
    haddr[15:12] == `ECA_SPACE_MISC && haddr[11:2] != `ECA_IDX_CRC_EXPOSE &&
    haddr[11:2] != `ECA_IDX_ACS_EXPOSE |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  // acs shows from reset on until software hides it
  a_acs_reset_shown: assert property ( // see (RQ14)
    !seen_acs_wr |-> acs_visible)
    else $error("acs hidden before any write");
  a_acs_expose_bit: assert property (wr_acs_exp |=> // see (RQ15)
    acs_visible == $past(hwdata[2]))
    else $error("acs exposure does not follow bit 2");
  a_crc_reset_hidden: assert property (!seen_crc_wr |-> // see (RQ19)
    crc_gen_visible == 4'h0 && crc_chk_visible == 4'h0 &&
    crc_append_en == 4'h0)
    else $error("ecrc visible before any write");
  // bus answer: reads wait one cycle, writes none
  a_read_one_wait: assert property (rd_accept |=> !hreadyout ##1
    hreadyout && !hresp)
    else $error("read answer timing wrong");
  a_write_no_wait: assert property (wr_accept |=> hreadyout && !hresp)
    else $error("write answer not ready");

  // main scenarios
  c_gen_enabled: cover property (wr_port_crc ##1 |crc_append_en);
  c_chk_enabled: cover property (wr_port_crc ##1 |crc_check_en);
  c_acs_hidden: cover property (wr_acs_exp ##1 !acs_visible);
  c_read_back: cover property (rd_accept ##2 hrdata != 32'h0);
  c_acs_ctrl_read: cover property (rd_port_hit &&
    haddr[11:2] == `ECA_IDX_ACS_CTRL ##2 hrdata[6:0] != 7'h00);

endmodule : eca_top

`default_nettype wire

// ===== dv/eca_ep_model.sv
// eca_ep_model.sv - endpoints that sit behind the four root ports
`timescale 1ns/1ps
`default_nettype none

module eca_ep_model #(
  parameter logic [3:0] CHK_CAP = 4'h5, // endpoints able to check crc
  parameter logic [3:0] GEN_CAP = 4'h3 // endpoints able to make crc
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] append_en,
  output logic [3:0] chk_capable,
  output logic [3:0] gen_capable,
  output logic [3:0] ignored
);
  // ----------------------------------------------------------------
  // capabilities found by firmware during enumeration
  // ----------------------------------------------------------------
  assign chk_capable = CHK_CAP;
  assign gen_capable = GEN_CAP;

  // ----------------------------------------------------------------
  // crc field reaching an endpoint without support is dropped
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ignored <= 4'h0;
    end else begin
      ignored <= append_en & ~CHK_CAP;
    end
  end
endmodule : eca_ep_model

`default_nettype wire

// ===== dv/eca_top_tb.sv
// eca_top_tb.sv - register level bench for the exposure block
`timescale 1ns/1ps
`default_nettype none
`include "eca_defines.svh"

module eca_top_tb
  import eca_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, acs_visible;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] crc_append_en, crc_check_en;
  logic [3:0] crc_gen_visible, crc_chk_visible;
  logic [3:0] ep_chk, ep_gen, ep_ignored;
  logic [31:0] e, v;
  int n_errors = 0;
  int check_count = 0;
  int gen_bit[4] = '{`ECA_GEN_ONE, `ECA_GEN_TWO, `ECA_GEN_THREE_A,
    `ECA_GEN_THREE_B};
  int chk_bit[4] = '{`ECA_CHK_ONE, `ECA_CHK_TWO, `ECA_CHK_THREE_A,
    `ECA_CHK_THREE_B};

  eca_top u_eca_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .crc_append_en(crc_append_en),
    .crc_check_en(crc_check_en), .crc_gen_visible(crc_gen_visible),
    .crc_chk_visible(crc_chk_visible), .acs_visible(acs_visible));

  eca_ep_model u_eca_ep_model (.hclk(hclk), .hresetn(hresetn),
    .append_en(crc_append_en), .chk_capable(ep_chk),
    .gen_capable(ep_gen), .ignored(ep_ignored));

  // clock of 20 ns
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] ra(input logic [3:0] sp,
    input logic [9:0] idx);
    return {16'h0000, sp, idx, 2'b00};
  endfunction : ra

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [2:0] sz,
    input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, 3'b010, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, 3'b010, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rdchk

  // let register and enable updates land
  task automatic settle;
    repeat (2) @(posedge hclk);
  endtask : settle

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // cut a hang short
  initial begin
    repeat (4000) @(posedge hclk);
    n_errors++;
    $display("unexpected at %0t: run too long", $time);
    finish_test;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values
    chk({15'h0, acs_visible, crc_gen_visible, crc_chk_visible,
      crc_append_en, crc_check_en}, 32'h0001_0000);
    rdchk(ra(4'h0, `ECA_IDX_CRC_EXPOSE), 32'h0000_0000);
    rdchk(ra(4'h0, `ECA_IDX_ACS_EXPOSE), 32'h0000_0004);
    rdchk(ra(4'h1, `ECA_IDX_CRC_CTRL), 32'h0000_0000);
    rdchk(ra(4'h3, `ECA_IDX_ACS_CAP), `ECA_ACS_CAP_HDR);
    $display("test reset done");
    // one core at a time
    for (int c = 0; c < 4; c++) begin
      e = (32'h1 << gen_bit[c]) | (32'h1 << chk_bit[c]);
      wr(ra(4'h0, `ECA_IDX_CRC_EXPOSE), e);
      settle;
      chk({28'h0, crc_gen_visible}, 32'h1 << c);
      chk({28'h0, crc_chk_visible}, 32'h1 << c);
      rdchk(ra(4'(c + 1), `ECA_IDX_CRC_CTRL), 32'h0000_00a0);
      rdchk(ra(4'((c + 1) % 4 + 1), `ECA_IDX_CRC_CTRL), 0);
      rdchk(ra(4'h0, `ECA_IDX_CRC_EXPOSE), e);
    end
    $display("test core exposure done");
    // firmware policy from endpoint abilities
    e = 32'h0000_0000;
    for (int c = 0; c < 4; c++) begin
      if (ep_chk[c]) e = e | (32'h1 << gen_bit[c]);
      if (ep_gen[c]) e = e | (32'h1 << chk_bit[c]);
    end
    wr(ra(4'h0, `ECA_IDX_CRC_EXPOSE), e);
    for (int c = 0; c < 4; c++) begin
      v = (ep_chk[c] ? 32'h40 : 32'h0) | (ep_gen[c] ? 32'h100 : 32'h0);
      wr(ra(4'(c + 1), `ECA_IDX_CRC_CTRL), v);
    end
    settle;
    chk({28'h0, crc_append_en}, {28'h0, ep_chk});
    chk({28'h0, crc_check_en}, {28'h0, ep_gen});
    chk({28'h0, ep_ignored}, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      v = (ep_chk[c] ? 32'h60 : 32'h0) | (ep_gen[c] ? 32'h180 : 32'h0);
      rdchk(ra(4'(c + 1), `ECA_IDX_CRC_CTRL), v);
    end
    wr(ra(4'h4, `ECA_IDX_CRC_CTRL), 32'h0000_0140);
    settle;
    chk({28'h0, crc_append_en}, {28'h0, ep_chk});
    // crc sent to an endpoint that cannot check it is ignored there
    wr(ra(4'h0, `ECA_IDX_CRC_EXPOSE), e | (32'h1 << gen_bit[1]));
    wr(ra(4'h2, `ECA_IDX_CRC_CTRL), 32'h0000_0040);
    settle;
    chk({28'h0, crc_append_en}, {28'h0, ep_chk | 4'h2});
    chk({28'h0, ep_ignored}, 32'h0000_0002);
    wr(ra(4'h0, `ECA_IDX_CRC_EXPOSE), 32'h0000_0000);
    settle;
    chk({24'h0, crc_append_en, crc_check_en}, 0);
    $display("test enables done");
    // acs exposure and control
    wr(ra(4'h1, `ECA_IDX_ACS_CTRL), 32'h0000_005d);
    rdchk(ra(4'h1, `ECA_IDX_ACS_CTRL), 32'h0000_005d);
    wr(ra(4'h0, `ECA_IDX_ACS_EXPOSE), 32'h0000_0000);
    settle;
    chk({31'h0, acs_visible}, 32'h0000_0000);
    rdchk(ra(4'h2, `ECA_IDX_ACS_CAP), 32'h0000_0000);
    rdchk(ra(4'h1, `ECA_IDX_ACS_CTRL), 32'h0000_0000);
    wr(ra(4'h0, `ECA_IDX_ACS_EXPOSE), 32'h0000_0004);
    settle;
    chk({31'h0, acs_visible}, 32'h0000_0001);
    rdchk(ra(4'h4, `ECA_IDX_ACS_CAP), `ECA_ACS_CAP_HDR);
    rdchk(ra(4'h1, `ECA_IDX_ACS_CTRL), 32'h0000_005d);
    $display("test acs done");
    // refused accesses
    bus(1'b1, 3'b000, ra(4'h0, `ECA_IDX_CRC_EXPOSE), 32'hffff_ffff, v);
    rdchk(ra(4'h0, `ECA_IDX_CRC_EXPOSE), 32'h0000_0000);
    wr(ra(4'h0, 10'h100), 32'hffff_ffff);
    rdchk(ra(4'h0, 10'h100), 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0000_0000);
    $display("test refusals done");
    finish_test;
  end
endmodule : eca_top_tb

`default_nettype wire
